// >>> shared/isc_pkg.sv
// Package for the link status and SCL timing block: register map,
// status bit positions, period offsets and the carrier structs.
// Assumes a 32-bit peripheral register port and one clock domain.
package isc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] LINK_STATUS_OFFSET     = 12'h00c;
	localparam logic [11:0] SCL_HIGH_PERIOD_OFFSET = 12'h010;
	localparam logic [11:0] SCL_LOW_PERIOD_OFFSET  = 12'h014;
	localparam logic [31:0] REG_RESET_VALUE        = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int DIRECTION_BIT  = 21;
	localparam int MASTER_BIT     = 20;
	localparam int OCCUPIED_BIT   = 19;
	localparam int RX_FULL_BIT    = 18;
	localparam int TX_EMPTY_BIT   = 17;
	localparam int RX_NONEMPTY_BIT = 16;
	localparam int TIMEOUT_BIT    = 11;
	localparam int MISPLACED_BIT  = 10;
	localparam int NACK_BIT       = 9;
	localparam int ARB_LOST_BIT   = 8;
	localparam int GEN_CALL_BIT   = 3;
	localparam int ADDRESS_BIT    = 2;
	localparam int STOP_SEEN_BIT  = 1;
	localparam int START_SENT_BIT = 0;

	// ----------------------------------------------------------------
	// SCL period offsets and filter codes
	// ----------------------------------------------------------------
	localparam logic [16:0] PERIOD_OFFSET_NO_FILTER  = 17'h00006;
	localparam logic [16:0] PERIOD_OFFSET_ONE_FILTER = 17'h00008;
	localparam logic [16:0] PERIOD_OFFSET_TWO_FILTER = 17'h00009;
	localparam logic [1:0]  FILTER_OFF               = 2'h0;
	localparam logic [1:0]  FILTER_ONE               = 2'h1;
	localparam logic [9:0]  GENERAL_CALL_ADDRESS     = 10'h000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       interface_enable;
		logic       ack_enable;
		logic       general_call_enable;
		logic [1:0] glitch_filter_select;
		logic       address_10bit;
		logic [9:0] own_address_register;
	} isc_control_type;

	typedef struct packed {
		logic       target_write;
		logic       data_write;
		logic       data_read;
		logic       stop_request;
	} isc_access_type;

	typedef struct packed {
		logic       direction_is_transmit;
		logic       frame_active;
		logic       sda_drive_low;
		logic       address_acked;
		logic       tx_byte_taken;
		logic       nack_received;
		logic       arbitration_lost;
		logic       timeout_underflow;
		logic       address_received;
		logic [9:0] received_address;
	} isc_engine_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} isc_bus_request_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} isc_bus_answer_type;

endpackage

// >>> verilog/isc_status_timing.sv
// Status flags, receive buffer and SCL period generation of a two-wire
// master/slave link controller, all on the peripheral clock sys_clk.
// Assumes a protocol engine on the same clock drives the engine events
// and the control fields; SDA and SCL arrive unsynchronised from pins.
// How it works
// - Bit 21 reads 1 while transmitting, 0 while receiving.
// - Master bit sets when target address written and bus idle.
// - Master bit clears on disable, STOP sent or bus error; read only.
// - Enabled, bus busy sets on SDA or SCL low, clears on STOP.
// - Receive full sets when data register and second buffer entry both hold bytes.
// - Transmit empty sets when data register empty, also after address frame.
// - Data write clears transmit empty; master STOP request or retarget also clears.
// - Receive not empty set while data register holds a byte; read clears.
// - Timeout underflow sets bit 11; writing one clears it.
// - Misplaced START or STOP sets bit 10; writing one clears it.
// - Bus error as master releases SDA and SCL with the flag.
// - NACK received while transmitting sets bit 9; writing one clears it.
// - Arbitration loss sets bit 8 that clock; writing one clears it.
// - Address zero with general call and ack enabled sets bit 3; read clears.
// - Master sets address flag bit 2 after slave acknowledges address.
// - Own address match with ack enabled sets address flag, enters slave mode.
// - Slave mode STOP sets bit 1; status read clears it.
// - Master START sent sets bit 0; status read clears it.
// - SCL high lasts high period setting plus offset clocks.
// - SCL low lasts low period setting plus same offset clocks.
// - Offset is 6, 8 or 9 by glitch filter setting.
// - Filter setting off, one-clock or two-clock glitch rejection.
`timescale 1ns/1ns
`default_nettype none

module isc_status_timing (
	input  wire logic                         sys_clk,
	input  wire logic                         srst,
	input  wire logic                         clk_en,
	input  wire isc_pkg::isc_bus_request_type bus_req,
	output var  isc_pkg::isc_bus_answer_type  bus_ans,
	input  wire isc_pkg::isc_control_type     ctrl,
	input  wire isc_pkg::isc_access_type      access,
	input  wire isc_pkg::isc_engine_type      engine,
	input  wire logic                         rx_byte_valid,
	input  wire logic [7:0]                   rx_byte,
	output logic                              rx_byte_ready,
	output logic                              rx_data_valid,
	output logic [7:0]                        rx_data,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe_n,
	input  wire logic                         scl_in,
	output logic                              scl_out,
	output logic                              scl_oe_n,
	output logic                              master_active,
	output logic                              slave_active
);
	import isc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {GEN_IDLE, GEN_START, GEN_LOW, GEN_HIGH, GEN_STOP} isc_gen_type;

	typedef struct packed {
		logic [1:0]       sda_sync;
		logic [1:0]       scl_sync;
		logic [1:0]       line;
		logic [1:0]       line_prev;
		logic [1:0][1:0]  glitch_cnt;
		logic             direction;
		logic             master;
		logic             slave;
		logic             occupied;
		logic             tx_empty;
		logic             timeout;
		logic             misplaced;
		logic             nack;
		logic             arb_lost;
		logic             gen_call;
		logic             address;
		logic             stop_seen;
		logic             start_sent;
		logic             stop_pending;
		logic [15:0]      high_period_count;
		logic [15:0]      low_period_count;
		logic [1:0]       rx_count;
		logic [1:0][7:0]  rx_mem;
		logic             rx_ready;
		logic             rx_valid;
		isc_gen_type      gen;
		logic [16:0]      gen_cnt;
		logic             sda_oe_n;
		logic             scl_oe_n;
		isc_bus_answer_type ans;
	} isc_state_type;

	isc_state_type r;
	isc_state_type next_r;

	logic        start_det;
	logic        stop_det;
	logic        bus_error;
	logic        status_read;
	logic        reg_write;
	logic        address_hit;
	logic        general_hit;
	logic [16:0] offset_d;
	logic [16:0] high_limit;
	logic [16:0] low_limit;
	logic [31:0] status_word;
	logic [1:0]  raw_line;
	logic [1:0]  filter_depth;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	always_comb begin
		unique case (ctrl.glitch_filter_select)
			FILTER_OFF: offset_d = PERIOD_OFFSET_NO_FILTER;
			FILTER_ONE: offset_d = PERIOD_OFFSET_ONE_FILTER;
			default:    offset_d = PERIOD_OFFSET_TWO_FILTER;
		endcase
		// Codes 10 and 11 both reject glitches of two clocks
		filter_depth = ctrl.glitch_filter_select[1] ? 2'h2 : ctrl.glitch_filter_select;

		high_limit = {1'b0, r.high_period_count} + offset_d;
		low_limit  = {1'b0, r.low_period_count} + offset_d;

		raw_line   = {r.sda_sync[1], r.scl_sync[1]};

		// Line index 1 is SDA, 0 is SCL; START is SDA falling while SCL high
		start_det  = r.line_prev[1] & ~r.line[1] & r.line[0] & r.line_prev[0];
		stop_det   = ~r.line_prev[1] & r.line[1] & r.line[0] & r.line_prev[0];
		// Own START and STOP are not misplaced
		bus_error  = ctrl.interface_enable & engine.frame_active & (start_det | stop_det)
			& (r.gen != GEN_START) & (r.gen != GEN_STOP);

		status_read = bus_req.psel & ~bus_req.penable & ~bus_req.pwrite
			& (bus_req.paddr == LINK_STATUS_OFFSET);
		reg_write   = bus_req.psel & bus_req.penable & bus_req.pwrite & r.ans.pready;

		general_hit = engine.address_received & ctrl.general_call_enable & ctrl.ack_enable
			& (ctrl.address_10bit ? engine.received_address == GENERAL_CALL_ADDRESS
				: engine.received_address[6:0] == GENERAL_CALL_ADDRESS[6:0]);
		address_hit = engine.address_received & ctrl.ack_enable
			& (ctrl.address_10bit ? engine.received_address == ctrl.own_address_register
				: engine.received_address[6:0] == ctrl.own_address_register[6:0]);

		status_word = REG_RESET_VALUE;
		status_word[DIRECTION_BIT]   = r.direction;
		status_word[MASTER_BIT]      = r.master;
		status_word[OCCUPIED_BIT]    = r.occupied;
		status_word[RX_FULL_BIT]     = r.rx_count == 2'h2;
		status_word[TX_EMPTY_BIT]    = r.tx_empty;
		status_word[RX_NONEMPTY_BIT] = r.rx_count != 2'h0;
		status_word[TIMEOUT_BIT]     = r.timeout;
		status_word[MISPLACED_BIT]   = r.misplaced;
		status_word[NACK_BIT]        = r.nack;
		status_word[ARB_LOST_BIT]    = r.arb_lost;
		status_word[GEN_CALL_BIT]    = r.gen_call;
		status_word[ADDRESS_BIT]     = r.address;
		status_word[STOP_SEEN_BIT]   = r.stop_seen;
		status_word[START_SENT_BIT]  = r.start_sent;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		if (clk_en) begin
			next_r.sda_sync  = {r.sda_sync[0], sda_in};
			next_r.scl_sync  = {r.scl_sync[0], scl_in};
			next_r.line_prev = r.line;
			// A new level is taken after it holds for filter_depth plus one samples
			for (int i = 0; i < 2; i++) begin
				if (raw_line[i] == r.line[i]) begin
					next_r.glitch_cnt[i] = 2'h0;
				end else if (r.glitch_cnt[i] >= filter_depth) begin
					next_r.line[i]       = raw_line[i];
					next_r.glitch_cnt[i] = 2'h0;
				end else begin
					next_r.glitch_cnt[i] = r.glitch_cnt[i] + 2'h1;
				end
			end

			// Bus monitor
			if (!ctrl.interface_enable) begin
				next_r.occupied = 1'b0;
			end else if (stop_det) begin
				next_r.occupied = 1'b0;
			end else if (r.line != 2'h3) begin
				next_r.occupied = 1'b1;
			end

			next_r.direction = engine.direction_is_transmit;

			// Register access: setup phase loads the answer, access phase completes
			next_r.ans.pready  = bus_req.psel & ~bus_req.penable;
			next_r.ans.pslverr = 1'b0;
			if (bus_req.psel & ~bus_req.penable) begin
				unique case (bus_req.paddr)
					LINK_STATUS_OFFSET:     next_r.ans.prdata = status_word;
					SCL_HIGH_PERIOD_OFFSET: next_r.ans.prdata = {16'h0000, r.high_period_count};
					SCL_LOW_PERIOD_OFFSET:  next_r.ans.prdata = {16'h0000, r.low_period_count};
					default:                next_r.ans.prdata = REG_RESET_VALUE;
				endcase
			end

			if (reg_write && bus_req.paddr == SCL_HIGH_PERIOD_OFFSET) begin
				next_r.high_period_count = bus_req.pwdata[15:0];
			end
			if (reg_write && bus_req.paddr == SCL_LOW_PERIOD_OFFSET) begin
				next_r.low_period_count = bus_req.pwdata[15:0];
			end

			// Write-one-to-clear flags; set wins over clear
			if (reg_write && bus_req.paddr == LINK_STATUS_OFFSET) begin
				if (bus_req.pwdata[TIMEOUT_BIT]) next_r.timeout = 1'b0;
				if (bus_req.pwdata[MISPLACED_BIT]) next_r.misplaced = 1'b0;
				if (bus_req.pwdata[NACK_BIT]) next_r.nack = 1'b0;
				if (bus_req.pwdata[ARB_LOST_BIT]) next_r.arb_lost = 1'b0;
			end
			// Read-to-clear flags
			if (status_read) begin
				next_r.gen_call   = 1'b0;
				next_r.address    = 1'b0;
				next_r.stop_seen  = 1'b0;
				next_r.start_sent = 1'b0;
			end

			if (engine.timeout_underflow) next_r.timeout = 1'b1;
			if (bus_error) next_r.misplaced = 1'b1;
			if (engine.nack_received & engine.direction_is_transmit) next_r.nack = 1'b1;
			if (engine.arbitration_lost) next_r.arb_lost = 1'b1;
			if (general_hit) next_r.gen_call = 1'b1;

			if (engine.address_acked & r.master) next_r.address = 1'b1;

			if (address_hit | general_hit) begin
				next_r.address = 1'b1;
				next_r.slave   = 1'b1;
			end

			if (stop_det & r.slave) begin
				next_r.stop_seen = 1'b1;
				next_r.slave     = 1'b0;
			end

			// Transmit data register empty
			if (access.data_write
				|| (r.master && (access.stop_request || access.target_write))) begin
				next_r.tx_empty = 1'b0;
			end
			if (engine.direction_is_transmit & (engine.address_acked | engine.tx_byte_taken)) begin
				next_r.tx_empty = 1'b1;
			end

			// Two-entry receive buffer: head is the data register
			if (access.data_read && r.rx_count != 2'h0) begin
				next_r.rx_mem[0] = r.rx_mem[1];
				next_r.rx_count  = r.rx_count - 2'h1;
			end

			if (rx_byte_valid && r.rx_count != 2'h2) begin
				next_r.rx_mem[next_r.rx_count[0]] = rx_byte;
				next_r.rx_count = next_r.rx_count + 2'h1;
			end
			// Buffer flags go out as registers
			next_r.rx_ready = next_r.rx_count != 2'h2;
			next_r.rx_valid = next_r.rx_count != 2'h0;

			if (access.stop_request & r.master) next_r.stop_pending = 1'b1;

			// SCL period generator
			next_r.gen_cnt = r.gen_cnt + 17'h00001;
			unique case (r.gen)
				GEN_IDLE: begin
					next_r.sda_oe_n = 1'b1;
					next_r.scl_oe_n = 1'b1;
					next_r.gen_cnt  = 17'h00000;
					if (access.target_write && ctrl.interface_enable && !r.occupied) begin
						next_r.master   = 1'b1;
						next_r.sda_oe_n = 1'b0;
						next_r.gen      = GEN_START;
					end
				end
				GEN_START: begin
					if (r.gen_cnt + 17'h00001 >= high_limit) begin
						next_r.start_sent = 1'b1;
						next_r.scl_oe_n   = 1'b0;
						next_r.gen_cnt    = 17'h00000;
						next_r.gen        = GEN_LOW;
					end
				end
				GEN_LOW: begin
					next_r.sda_oe_n = r.stop_pending ? 1'b0 : ~engine.sda_drive_low;
					if (r.gen_cnt + 17'h00001 >= low_limit) begin
						next_r.scl_oe_n = 1'b1;
						next_r.gen_cnt  = 17'h00000;
						next_r.gen      = r.stop_pending ? GEN_STOP : GEN_HIGH;
					end
				end
				GEN_HIGH: begin
					// Filtered SCL rises within d clocks of release; a later low is a stretch
					if (!r.line[0] && r.gen_cnt >= offset_d) begin
						next_r.gen_cnt = r.gen_cnt;
					end else if (r.gen_cnt + 17'h00001 >= high_limit) begin
						next_r.scl_oe_n = 1'b0;
						next_r.gen_cnt  = 17'h00000;
						next_r.gen      = GEN_LOW;
					end
				end
				GEN_STOP: begin
					if (r.gen_cnt + 17'h00001 >= high_limit) begin
						next_r.sda_oe_n     = 1'b1;
						next_r.master       = 1'b0;
						next_r.stop_pending = 1'b0;
						next_r.gen          = GEN_IDLE;
					end
				end
				default: next_r.gen = GEN_IDLE;
			endcase

			// Bus error or disable drops the master role and frees both lines
			if (bus_error || !ctrl.interface_enable) begin
				next_r.master       = 1'b0;
				next_r.stop_pending = 1'b0;
				next_r.sda_oe_n     = 1'b1;
				next_r.scl_oe_n     = 1'b1;
				next_r.gen          = GEN_IDLE;
			end

			if (!ctrl.interface_enable) next_r.slave = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			r          <= '0;
			r.sda_sync <= 2'h3;
			r.scl_sync <= 2'h3;
			r.line     <= 2'h3;
			r.line_prev <= 2'h3;
			r.gen      <= GEN_IDLE;
			r.sda_oe_n <= 1'b1;
			r.scl_oe_n <= 1'b1;
			r.rx_ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_ans       = r.ans;
	assign rx_byte_ready = r.rx_ready;
	assign rx_data_valid = r.rx_valid;
	assign rx_data       = r.rx_mem[0];
	assign sda_out       = 1'b0;
	assign sda_oe_n      = r.sda_oe_n;
	assign scl_out       = 1'b0;
	assign scl_oe_n      = r.scl_oe_n;
	assign master_active = r.master;
	assign slave_active  = r.slave;

endmodule

`default_nettype wire

// >>> sim/isc_far_party.sv
// Far-side party on the open-drain link: makes START and STOP frames.
// Assumes pull-ups in the bench, so a released line reads high.
`timescale 1ns/1ns
`default_nettype none
module isc_far_party (
	output logic sda_pull_n,
	output logic scl_pull_n
);
	initial begin
		sda_pull_n = 1'b1;
		scl_pull_n = 1'b1;
	end
	// Lines idle high first, SDA falls while SCL is high, then SCL falls
	task automatic start_cond();
		sda_pull_n = 1'b1;
		scl_pull_n = 1'b1;
		#63;
		sda_pull_n = 1'b0;
		#62;
		scl_pull_n = 1'b0;
		#63;
	endtask
	// SDA low, SCL rises, then SDA rises and both stay released
	task automatic stop_cond();
		sda_pull_n = 1'b0;
		#62;
		scl_pull_n = 1'b1;
		#63;
		sda_pull_n = 1'b1;
		#63;
	endtask
endmodule
`default_nettype wire

// >>> sim/isc_status_timing_asserts.sv
// Assertions on the ports of the link status and SCL timing block.
// Assumes clk_en held high and period settings changed only while idle.
`timescale 1ns/1ns
`default_nettype none
module isc_status_timing_asserts (
	input wire logic                         sys_clk,
	input wire logic                         srst,
	input wire isc_pkg::isc_bus_request_type bus_req,
	input wire isc_pkg::isc_bus_answer_type  bus_ans,
	input wire isc_pkg::isc_control_type     ctrl,
	input wire isc_pkg::isc_access_type      access,
	input wire isc_pkg::isc_engine_type      engine,
	input wire logic                         rx_byte_valid,
	input wire logic [7:0]                   rx_byte,
	input wire logic                         rx_byte_ready,
	input wire logic                         rx_data_valid,
	input wire logic [7:0]                   rx_data,
	input wire logic                         sda_oe_n,
	input wire logic                         scl_oe_n,
	input wire logic                         master_active,
	input wire logic                         slave_active
);
	import isc_pkg::*;
	logic [15:0] low_set;
	logic [16:0] low_cnt;
	logic [16:0] dval;
	// ----------------------------------------------------------------
	// Low period reference
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst)
			low_set <= 16'h0000;
		else if (bus_req.psel && bus_req.penable && bus_req.pwrite && bus_req.paddr == SCL_LOW_PERIOD_OFFSET)
			low_set <= bus_req.pwdata[15:0];
	end
	always_ff @(posedge sys_clk) begin
		if (srst || scl_oe_n)
			low_cnt <= 17'h00000;
		else
			low_cnt <= low_cnt + 17'h00001;
	end
	always_comb begin
		if (ctrl.glitch_filter_select == FILTER_OFF)
			dval = PERIOD_OFFSET_NO_FILTER;
		else if (ctrl.glitch_filter_select == FILTER_ONE)
			dval = PERIOD_OFFSET_ONE_FILTER;
		else
			dval = PERIOD_OFFSET_TWO_FILTER;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence s_status_setup;
		bus_req.psel && !bus_req.penable && !bus_req.pwrite && bus_req.paddr == LINK_STATUS_OFFSET;
	endsequence
	sequence s_second_push;
		rx_data_valid && rx_byte_valid && rx_byte_ready && !access.data_read;
	endsequence
	chk_bus_answer:
		assert property (bus_req.psel && !bus_req.penable |=> bus_ans.pready && !bus_ans.pslverr)
		else $error("access phase not answered");
	chk_reserved_zero:
		assert property (s_status_setup |=> (bus_ans.prdata & 32'hffc0_f0f0) == 32'h0000_0000)
		else $error("reserved status bit set");
	chk_direction_read:
		assert property (s_status_setup |=> bus_ans.prdata[DIRECTION_BIT] == $past(engine.direction_is_transmit, 2))
		else $error("direction bit wrong");
	chk_master_origin:
		assert property ($rose(master_active) |-> $past(access.target_write) && $past(ctrl.interface_enable))
		else $error("master role without target write");
	chk_role_disable:
		assert property (!ctrl.interface_enable |=> !master_active && !slave_active)
		else $error("role kept while disabled");
	chk_master_release:
		assert property ($fell(master_active) |-> ##[0:1] (sda_oe_n && scl_oe_n))
		else $error("lines held after master role ended");
	chk_rx_capture:
		assert property (rx_byte_valid && rx_byte_ready && !rx_data_valid |=> rx_data_valid && rx_data == $past(rx_byte))
		else $error("received byte not presented");
	chk_rx_hold:
		assert property (rx_data_valid && !access.data_read |=> rx_data_valid && $stable(rx_data))
		else $error("unread byte lost");
	chk_full_refuse:
		assert property (s_second_push |=> !rx_byte_ready)
		else $error("third byte accepted");
	chk_scl_low_span:
		assert property ($rose(scl_oe_n) && master_active |-> low_cnt == {1'b0, low_set} + dval)
		else $error("scl low span wrong");
endmodule
`default_nettype wire

// >>> sim/isc_status_timing_tb.sv
// Bench for the link status and SCL timing block with a status model.
// Assumes pull-ups on both open-drain lines and clk_en held high.
`timescale 1ns/1ns
`default_nettype none
module isc_status_timing_tb;
	import isc_pkg::*;
	localparam logic [31:0] SMASK = 32'h003f_0f0f;
	logic                sys_clk;
	logic                srst;
	logic                clk_en;
	isc_bus_request_type br;
	isc_bus_answer_type  ans;
	isc_control_type     ctl;
	isc_access_type      acc;
	isc_engine_type      eng;
	logic                rx_byte_valid;
	logic [7:0]          rx_byte;
	logic                rx_byte_ready;
	logic                rx_data_valid;
	logic [7:0]          rx_data;
	logic                sda_out;
	logic                sda_oe_n;
	logic                scl_out;
	logic                scl_oe_n;
	logic                master_active;
	logic                slave_active;
	logic                p_sda_n;
	logic                p_scl_n;
	wire                 sda_line;
	wire                 scl_line;
	logic [31:0]         lfsr = 32'hd6d7aefd;
	logic [31:0]         mdl;
	logic [31:0]         rdv;
	logic [31:0]         v;
	logic [7:0]          rxq[$];
	int                  err_total;
	int                  samples_checked;
	int                  n;
	int                  hp;
	int                  d;
	int                  evs[4] = '{15, 13, 12, 11};
	logic [11:0]         regs[4] = '{LINK_STATUS_OFFSET, SCL_HIGH_PERIOD_OFFSET, SCL_LOW_PERIOD_OFFSET, 12'h018};
	assign sda_line = (sda_oe_n | sda_out) & p_sda_n;
	assign scl_line = (scl_oe_n | scl_out) & p_scl_n;
	isc_status_timing u_dut (
		.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .bus_req(br), .bus_ans(ans), .ctrl(ctl),
		.access(acc), .engine(eng), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.rx_byte_ready(rx_byte_ready), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl_line), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .master_active(master_active), .slave_active(slave_active)
	);
	isc_far_party far (.sda_pull_n(p_sda_n), .scl_pull_n(p_scl_n));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] next_rand();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		@(posedge sys_clk);
		br <= '{1'b1, 1'b0, 1'b0, a, 32'h0000_0000};
		@(posedge sys_clk);
		br.penable <= 1'b1;
		@(posedge sys_clk);
		q = ans.prdata;
		chk("pready", 32'(ans.pready), 32'h0000_0001);
		br.psel <= 1'b0;
		br.penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		br <= '{1'b1, 1'b0, 1'b1, a, x};
		@(posedge sys_clk);
		br.penable <= 1'b1;
		@(posedge sys_clk);
		br.psel <= 1'b0;
		br.penable <= 1'b0;
	endtask
	// Status read compared with the model; the read clears bits 3 to 0
	task automatic st();
		rd(LINK_STATUS_OFFSET, rdv);
		chk("status", rdv & SMASK, mdl & SMASK);
		mdl = mdl & 32'hffff_fff0;
	endtask
	task automatic pulse(input bit a, input int b);
		@(posedge sys_clk);
		if (a) acc[b] <= 1'b1;
		else eng[b] <= 1'b1;
		@(posedge sys_clk);
		if (a) acc[b] <= 1'b0;
		else eng[b] <= 1'b0;
	endtask
	task automatic push(input logic [7:0] b);
		@(posedge sys_clk);
		rx_byte_valid <= 1'b1;
		rx_byte <= b;
		@(posedge sys_clk);
		if (rx_byte_ready === 1'b1) rxq.push_back(b);
		rx_byte_valid <= 1'b0;
	endtask
	task automatic wait_line(input int w, input logic lv, output int k);
		k = 0;
		while ((w == 0 ? sda_oe_n : w == 1 ? scl_oe_n : master_active) !== lv && k < 3000) begin
			@(posedge sys_clk);
			k++;
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		br = '0;
		ctl = '0;
		acc = '0;
		eng = '0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		mdl = 32'h0000_0000;
		cyc(2);
		srst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], rdv);
			chk("reset value", rdv, REG_RESET_VALUE);
		end
		for (int i = 1; i < 3; i++) begin
			v = next_rand();
			wr(regs[i], v);
			rd(regs[i], rdv);
			chk("period", rdv, v & 32'h0000_ffff);
		end
		$display("register test done");
		for (int f = 0; f < 4; f++) begin
			ctl <= '{1'b1, 1'b1, 1'b1, 2'(f), 1'b0, 10'h05a};
			d = (f == 0) ? 6 : (f == 1) ? 8 : 9;
			hp = 2 + int'(next_rand() & 32'h7);
			wr(SCL_HIGH_PERIOD_OFFSET, 32'(hp));
			wr(SCL_LOW_PERIOD_OFFSET, next_rand() & 32'h7);
			pulse(1, 3);
			mdl = mdl | 32'h0018_0001;
			wait_line(0, 1'b0, n);
			wait_line(1, 1'b0, n);
			chk("high span", 32'(n), 32'(hp + d));
			eng.direction_is_transmit <= 1'b1;
			foreach (evs[i]) pulse(0, evs[i]);
			mdl = mdl | 32'h0022_0b04;
			st();
			pulse(1, 2);
			mdl[17] = 1'b0;
			st();
			pulse(0, 14);
			mdl[17] = 1'b1;
			wr(LINK_STATUS_OFFSET, 32'h0000_0000);
			st();
			wr(LINK_STATUS_OFFSET, 32'hffff_ffff);
			mdl = mdl & 32'hffff_f0ff;
			st();
			pulse(1, 0);
			mdl[17] = 1'b0;
			wait_line(2, 1'b0, n);
			cyc(20);
			mdl = mdl & 32'hffe7_ffff;
			st();
			eng.direction_is_transmit <= 1'b0;
			mdl[21] = 1'b0;
		end
		$display("master test done");
		for (int i = 0; i < 3; i++) push(8'(next_rand()));
		cyc(1);
		chk("refused", 32'(rx_byte_ready), 32'h0000_0000);
		mdl = mdl | 32'h0005_0000;
		st();
		while (rxq.size() > 0) begin
			chk("rx data", 32'(rx_data), 32'(rxq.pop_front()));
			pulse(1, 1);
			cyc(1);
		end
		mdl = mdl & 32'hfffa_ffff;
		st();
		$display("receive test done");
		far.start_cond();
		eng.received_address <= 10'h05a;
		pulse(0, 10);
		cyc(1);
		chk("slave", 32'(slave_active), 32'h0000_0001);
		eng.frame_active <= 1'b1;
		far.start_cond();
		eng.frame_active <= 1'b0;
		far.stop_cond();
		cyc(10);
		mdl = mdl | 32'h0000_0406;
		st();
		chk("slave", 32'(slave_active), 32'h0000_0000);
		wr(LINK_STATUS_OFFSET, 32'h0000_0400);
		mdl[10] = 1'b0;
		st();
		$display("slave test done");
		eng.received_address <= 10'h000;
		pulse(0, 10);
		mdl[3:2] = 2'h3;
		st();
		st();
		ctl.interface_enable <= 1'b0;
		cyc(2);
		chk("role", {30'h0, master_active, slave_active}, 32'h0000_0000);
		$display("general call test done");
		report_and_stop();
	end
endmodule
bind isc_status_timing isc_status_timing_asserts u_chk (
	.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .bus_ans(bus_ans), .ctrl(ctrl), .access(access),
	.engine(engine), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_byte_ready(rx_byte_ready),
	.rx_data_valid(rx_data_valid), .rx_data(rx_data), .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
	.master_active(master_active), .slave_active(slave_active)
);
`default_nettype wire
